//--- logic/flash_status_pkg.sv
/*
 Shared constants and types of the flash access status block: register
 offsets, field positions, reset values, event layout, bus carriers.
 Assumes one 200 MHz clock and a plain strobe register port.
*/
package flash_status_pkg;

   // register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] INT_CLR_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] INT_EN_OFS = 8'h0c;

   // flash_access_error_status fields
   localparam int FLAG_BIT = 7;
   localparam int RSVD_HI_BIT = 6;
   localparam int RSVD_LO_BIT = 5;
   localparam int LOCK_BIT = 4;
   localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

   // interrupt event layout, shared by status, clear and enable
   localparam int EV_W = 3;
   localparam int EV_FLAG = 0;
   localparam int EV_LOCK = 1;
   localparam int EV_UNLOCK = 2;
   localparam logic [EV_W-1:0] INT_RST = 3'h0;

   // synchroniser reset level of the mode pin
   localparam logic PIN_RST = 1'b0;

   typedef enum logic [0:0] {
      LOCK_OPEN = 1'b0,
      LOCK_HELD = 1'b1
   } lock_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic access_err;
      logic cmd_err;
      logic clear_done;
   } unit_ev_t;

endpackage

//--- logic/pin_level_sync.sv
/*
 Three-stage synchroniser for a slow level arriving from a pin.
 Assumes the pin changes rarely; the output follows only once the
 second and third stages agree.
*/
`timescale 1ns/1ps
module pin_level_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pin and filtered level
   input wire logic pin_i,
   output logic level_o
);
   import flash_status_pkg::*;

   logic s1_q, s2_q, s3_q, level_q;
   logic level_d;

   always_comb begin
      level_d = level_q;
      // first stage is read by the second stage only
      if (s2_q == s3_q) begin
         level_d = s3_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= PIN_RST;
         s2_q <= PIN_RST;
         s3_q <= PIN_RST;
         level_q <= PIN_RST;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_q <= level_d;
      end
   end

   assign level_o = level_q;

endmodule

//--- logic/flash_access_status.sv
/*
 Flash access error status register with command-lock tracking and a
 small interrupt front end, reached over a plain strobe register port.
 Assumes the command unit gives one-cycle pulses on this clock and the
 on-chip ROM mode arrives as a pin level.
*/
// How it works
// RULE1 - With the on-chip ROM disabled the status register reads zero and ignores writes.
// RULE2 - The command unit is held locked while any status bit is one.
// RULE3 - Software leaves the lock by writing only the lock bit, then issuing a status-clear command.
// RULE4 - Power-on reset starts the error flag and the lock indication at zero.
// RULE5 - The access error flag clears only when zero is written after it was read as one.
// RULE6 - Reserved bits 6 and 5 read as zero and software writes them as zero.
// RULE7 - Bit 4 is a read-only lock indicator, set when the unit sees an error and locks.
// RULE8 - The lock indicator clears when the unit finishes a status-clear command.
// RULE9 - The access error flag sets on an access error and holds until cleared by software.
`timescale 1ns/1ps
module flash_access_status (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // register port
   input wire flash_status_pkg::bus_req_t BUS_REQ_I,
   output logic [flash_status_pkg::DATA_W-1:0] RDATA_O,
   // command unit side
   input wire flash_status_pkg::unit_ev_t UNIT_EV_I,
   input wire logic ROM_DISABLED_I,
   output logic COMMAND_LOCK_O,
   // interrupt
   output logic IRQ_O
);
   import flash_status_pkg::*;

   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] ofs
   );
      return a == ofs;
   endfunction

   function automatic logic [DATA_W-1:0] status_word(
      input logic err_flag,
      input logic lock_ind
   );
      logic [DATA_W-1:0] w;
      w = STATUS_RST;
      w[FLAG_BIT] = err_flag;
      w[LOCK_BIT] = lock_ind;
      return w;
   endfunction

   // mode pin
   logic rom_off;

   pin_level_sync u_rom_mode (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .pin_i(ROM_DISABLED_I),
      .level_o(rom_off)
   );

   // access decode
   logic st_wr, st_rd, clr_wr, en_wr;

   // status register disappears while the ROM is off
   assign st_wr = BUS_REQ_I.wr && hit(BUS_REQ_I.addr, STATUS_OFS)
      && !rom_off; // [RULE1]
   assign st_rd = BUS_REQ_I.rd && hit(BUS_REQ_I.addr, STATUS_OFS)
      && !rom_off; // [RULE1]
   assign clr_wr = BUS_REQ_I.wr && hit(BUS_REQ_I.addr, INT_CLR_OFS);
   assign en_wr = BUS_REQ_I.wr && hit(BUS_REQ_I.addr, INT_EN_OFS);

   // status group
   logic flag_q, flag_d;
   logic armed_q, armed_d;
   lock_state_t lock_q, lock_d;
   logic cmd_lock_q, cmd_lock_d;
   logic lock_now, lock_next;

   // lock indicator is the state bit itself; bus writes never reach it,
   // so only a finished status-clear can clear the lock indicator
   assign lock_now = (lock_q == LOCK_HELD);
   assign lock_next = (lock_d == LOCK_HELD);

   always_comb begin
      flag_d = flag_q;
      armed_d = armed_q;
      lock_d = lock_q;
      // a read that shows the flag as one arms the clear
      if (st_rd && flag_q) begin
         armed_d = 1'b1; // [RULE5]
      end
      // bit 4 and reserved bits ignore writes; a 0x10 write keeps lock
      if (st_wr) begin
         if (armed_q && !BUS_REQ_I.wdata[FLAG_BIT]) begin
            flag_d = 1'b0; // [RULE5] [RULE3]
         end
         armed_d = 1'b0;
      end
      // new error beats a clear in the same cycle
      if (UNIT_EV_I.access_err) begin
         flag_d = 1'b1; // [RULE9]
      end
      case (lock_q)
         LOCK_OPEN: begin
            if (UNIT_EV_I.cmd_err || UNIT_EV_I.access_err) begin
               lock_d = LOCK_HELD; // [RULE7]
            end
         end
         LOCK_HELD: begin
            // an error in the finishing cycle keeps the lock
            if (UNIT_EV_I.clear_done && !UNIT_EV_I.cmd_err
                  && !UNIT_EV_I.access_err) begin
               lock_d = LOCK_OPEN; // [RULE8]
            end
         end
         default: begin
            lock_d = LOCK_OPEN;
         end
      endcase
      // any set bit locks the unit, so the flag alone also holds it
      cmd_lock_d = flag_d || (lock_d == LOCK_HELD); // [RULE2]
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         flag_q <= 1'b0; // [RULE4]
         armed_q <= 1'b0;
         lock_q <= LOCK_OPEN; // [RULE4]
         cmd_lock_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         armed_q <= armed_d;
         lock_q <= lock_d;
         cmd_lock_q <= cmd_lock_d;
      end
   end

   assign COMMAND_LOCK_O = cmd_lock_q;

   // interrupt group
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] int_stat_q, int_stat_d;
   logic [EV_W-1:0] int_en_q, int_en_d;
   logic irq_q, irq_d;

   // edges of registered state, so a reset release cannot fake an event
   assign ev[EV_FLAG] = flag_d && !flag_q;
   assign ev[EV_LOCK] = lock_next && !lock_now;
   assign ev[EV_UNLOCK] = lock_now && !lock_next;

   genvar g;
   generate
      for (g = 0; g < EV_W; g++) begin : g_sticky
         // set wins over a clear in the same cycle
         always_comb begin
            int_stat_d[g] = ev[g] || (int_stat_q[g]
               && !(clr_wr && BUS_REQ_I.wdata[g]));
         end
      end
   endgenerate

   always_comb begin
      int_en_d = int_en_q;
      if (en_wr) begin
         int_en_d = BUS_REQ_I.wdata[EV_W-1:0];
      end
      irq_d = |(int_stat_d & int_en_d);
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         int_stat_q <= INT_RST;
         int_en_q <= INT_RST;
         irq_q <= 1'b0;
      end else begin
         int_stat_q <= int_stat_d;
         int_en_q <= int_en_d;
         irq_q <= irq_d;
      end
   end

   assign IRQ_O = irq_q;

   // read group: data only in the cycle after the strobe
   logic [DATA_W-1:0] rdata_q, rdata_d;

   always_comb begin
      rdata_d = READ_IDLE;
      if (BUS_REQ_I.rd) begin
         case (BUS_REQ_I.addr)
            STATUS_OFS: begin
               // reserved bits 6 and 5 stay zero in the word
               if (rom_off) begin
                  rdata_d = READ_IDLE; // [RULE1]
               end else begin
                  rdata_d = status_word(flag_q, lock_now); // [RULE6]
               end
            end
            INT_STAT_OFS: begin
               rdata_d = {{(DATA_W-EV_W){1'b0}}, int_stat_q};
            end
            INT_EN_OFS: begin
               rdata_d = {{(DATA_W-EV_W){1'b0}}, int_en_q};
            end
            // clear register is write-only; unmapped reads zero
            default: begin
               rdata_d = READ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_q <= READ_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_O = rdata_q;

   // checks
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);

   logic st_rd_any;
   assign st_rd_any = BUS_REQ_I.rd && hit(BUS_REQ_I.addr, STATUS_OFS);

   disabled_read_zero_a: assert property ( // [RULE1]
      st_rd_any && rom_off |=> RDATA_O == READ_IDLE
   ) else $error("status read with ROM off was not zero");

   logic [EV_W-1:0] wr_ev_bits;
   assign wr_ev_bits = BUS_REQ_I.wdata[EV_W-1:0];

   disabled_write_ignored_a: assert property ( // [RULE1]
      BUS_REQ_I.wr && hit(BUS_REQ_I.addr, STATUS_OFS) && rom_off
      && !UNIT_EV_I.access_err |=> $stable(flag_q)
   ) else $error("status write with ROM off changed the flag");

   disabled_no_arm_a: assert property ( // [RULE1]
      st_rd_any && rom_off && !armed_q |=> !armed_q
   ) else $error("status read with ROM off armed the flag clear");

   lock_follows_bits_a: assert property ( // [RULE2]
      COMMAND_LOCK_O == (flag_q || lock_now)
   ) else $error("lock output does not match status bits");

   lock_out_flag_a: assert property ( // [RULE2]
      flag_q |-> COMMAND_LOCK_O
   ) else $error("set access error flag did not lock the unit");

   lock_write_kept_a: assert property ( // [RULE3]
      st_wr && lock_now && !UNIT_EV_I.clear_done |=> lock_now
   ) else $error("status write alone released the lock");

   flag_clear_seq_a: assert property ( // [RULE5]
      $fell(flag_q) |-> $past(armed_q) && $past(st_wr)
   ) else $error("access error flag cleared without read then write");

   // read and write need not be adjacent, so the arm bit is the witness
   flag_read_arm_a: assert property ( // [RULE5]
      st_wr && armed_q && !BUS_REQ_I.wdata[FLAG_BIT]
      && !UNIT_EV_I.access_err |=> !flag_q
   ) else $error("zero write after reading one did not clear flag");

   arm_after_read_a: assert property ( // [RULE5]
      $rose(armed_q) |-> $past(st_rd) && $past(flag_q)
   ) else $error("clear armed without a read of the set flag");

   flag_read_shown_a: assert property ( // [RULE5]
      st_rd |=> RDATA_O[FLAG_BIT] == $past(flag_q)
   ) else $error("status read does not show the access error flag");

   reserved_read_zero_a: assert property ( // [RULE6]
      st_rd_any |=> RDATA_O[RSVD_HI_BIT:RSVD_LO_BIT] == 2'h0
   ) else $error("reserved status bits read nonzero");

   lock_on_error_a: assert property ( // [RULE7]
      UNIT_EV_I.cmd_err |=> lock_now
   ) else $error("lock indicator not set after unit error");

   lock_set_cause_a: assert property ( // [RULE7]
      $rose(lock_now)
      |-> $past(UNIT_EV_I.cmd_err) || $past(UNIT_EV_I.access_err)
   ) else $error("lock indicator set without a unit error");

   lock_held_a: assert property ( // [RULE7]
      lock_now && !UNIT_EV_I.clear_done |=> lock_now
   ) else $error("lock indicator dropped without clear done");

   lock_read_shown_a: assert property ( // [RULE7]
      st_rd && !rom_off |=> RDATA_O[LOCK_BIT] == $past(lock_now)
   ) else $error("status read does not show lock state");

   lock_clear_done_a: assert property ( // [RULE8]
      lock_now && UNIT_EV_I.clear_done && !UNIT_EV_I.cmd_err
      && !UNIT_EV_I.access_err |=> !lock_now
   ) else $error("lock indicator not cleared on clear done");

   lock_err_keeps_a: assert property ( // [RULE8]
      lock_now && UNIT_EV_I.clear_done
      && (UNIT_EV_I.cmd_err || UNIT_EV_I.access_err) |=> lock_now
   ) else $error("error during clear done released the lock");

   lock_clear_cause_a: assert property ( // [RULE8]
      $fell(lock_now) |-> $past(UNIT_EV_I.clear_done)
   ) else $error("lock indicator cleared without clear done");

   flag_set_hold_a: assert property ( // [RULE9]
      UNIT_EV_I.access_err |=> flag_q [*2] or (flag_q ##1 $past(st_wr))
   ) else $error("access error flag not set or not held");

   flag_set_cause_a: assert property ( // [RULE9]
      $rose(flag_q) |-> $past(UNIT_EV_I.access_err)
   ) else $error("access error flag set without an access error");

   read_data_idle_a: assert property (
      !BUS_REQ_I.rd |=> RDATA_O == READ_IDLE
   ) else $error("read data not zero outside the answer cycle");

   int_set_wins_a: assert property (
      ev != INT_RST |=> (int_stat_q & $past(ev)) == $past(ev)
   ) else $error("interrupt event not latched in status");

   unlock_event_a: assert property (
      $fell(lock_now) |-> int_stat_q[EV_UNLOCK]
   ) else $error("lock release not latched as an interrupt event");

   int_clear_a: assert property (
      clr_wr && (wr_ev_bits & ev) == INT_RST
      |=> (int_stat_q & $past(wr_ev_bits)) == INT_RST
   ) else $error("interrupt clear write left a status bit set");

   int_enable_write_a: assert property (
      en_wr |=> int_en_q == $past(wr_ev_bits)
   ) else $error("interrupt enable write not stored");

   irq_level_a: assert property (
      IRQ_O == |(int_stat_q & int_en_q)
   ) else $error("interrupt output disagrees with status and enable");

endmodule

//--- verif/flash_access_status_tb.sv
/*
 Self-checking bench for the flash access status block: drives the
 strobe register port, command unit pulses and the ROM mode pin.
 Assumes a 200 MHz clock and the offsets and event layout of the package.
*/
`timescale 1ns/1ps
module flash_access_status_tb;
   import flash_status_pkg::*;

   localparam unit_ev_t ev_acc = '{1'b1, 1'b0, 1'b0};
   localparam unit_ev_t ev_cmd = '{1'b0, 1'b1, 1'b0};
   localparam unit_ev_t ev_done = '{1'b0, 1'b0, 1'b1};
   localparam unit_ev_t ev_cmd_done = '{1'b0, 1'b1, 1'b1};

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   bus_req_t bus_req = '0;
   unit_ev_t unit_ev = '0;
   logic rom_disabled = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic command_lock;
   logic irq;
   int miscompares = 0;
   int checked = 0;

   always #2.5 ref_clk = ~ref_clk;

   flash_access_status flash_access_status_i (
      .REF_CLK_I(ref_clk),
      .RST_I(rst),
      .BUS_REQ_I(bus_req),
      .RDATA_O(rdata),
      .UNIT_EV_I(unit_ev),
      .ROM_DISABLED_I(rom_disabled),
      .COMMAND_LOCK_O(command_lock),
      .IRQ_O(irq)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] expd);
      checked++;
      if (seen !== expd) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_req <= '0;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge ref_clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      check(rdata, e);
   endtask

   task automatic pulse(input unit_ev_t ev);
      @(posedge ref_clk);
      unit_ev <= ev;
      @(posedge ref_clk);
      unit_ev <= '0;
   endtask

   // levels are checked one cycle late, so latency slack is harmless
   task automatic lock_is(input logic e);
      @(posedge ref_clk);
      #1;
      check({7'h00, command_lock}, {7'h00, e});
   endtask

   task automatic irq_is(input logic e);
      @(posedge ref_clk);
      #1;
      check({7'h00, irq}, {7'h00, e});
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #20000;
      miscompares++;
      stop_test();
   end

   initial begin
      idle(6);
      rst <= 1'b0;
      rd(STATUS_OFS, 8'h00);
      rd(INT_STAT_OFS, 8'h00);
      rd(INT_EN_OFS, 8'h00);
      lock_is(1'b0);
      pulse(ev_acc);
      lock_is(1'b1);
      // write before any read must not clear the flag
      wr(STATUS_OFS, 8'h10);
      rd(STATUS_OFS, 8'h90);
      wr(STATUS_OFS, 8'h90);
      rd(STATUS_OFS, 8'h90);
      rd(INT_STAT_OFS, 8'h03);
      wr(STATUS_OFS, 8'h10);
      rd(STATUS_OFS, 8'h10);
      lock_is(1'b1);
      wr(STATUS_OFS, 8'h00);
      rd(STATUS_OFS, 8'h10);
      pulse(ev_done);
      lock_is(1'b0);
      rd(STATUS_OFS, 8'h00);
      pulse(ev_cmd);
      lock_is(1'b1);
      rd(STATUS_OFS, 8'h10);
      // an error in the finishing cycle keeps the unit locked
      pulse(ev_cmd_done);
      lock_is(1'b1);
      rd(STATUS_OFS, 8'h10);
      pulse(ev_done);
      rd(STATUS_OFS, 8'h00);
      // interrupt: all three events latched while masked
      rd(INT_STAT_OFS, 8'h07);
      irq_is(1'b0);
      wr(INT_EN_OFS, 8'h07);
      rd(INT_EN_OFS, 8'h07);
      irq_is(1'b1);
      wr(INT_CLR_OFS, 8'h07);
      irq_is(1'b0);
      rd(INT_STAT_OFS, 8'h00);
      wr(INT_EN_OFS, 8'h00);
      pulse(ev_acc);
      irq_is(1'b0);
      rd(INT_STAT_OFS, 8'h03);
      wr(INT_EN_OFS, 8'h01);
      irq_is(1'b1);
      wr(INT_CLR_OFS, 8'h01);
      irq_is(1'b0);
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00);
      // ROM disabled mode, pin passes a three-flop synchroniser
      @(posedge ref_clk);
      rom_disabled <= 1'b1;
      idle(6);
      rd(STATUS_OFS, 8'h00);
      wr(STATUS_OFS, 8'h00);
      lock_is(1'b1);
      @(posedge ref_clk);
      rom_disabled <= 1'b0;
      idle(6);
      rd(STATUS_OFS, 8'h90);
      // second reset in mid-run
      @(posedge ref_clk);
      rst <= 1'b1;
      idle(2);
      lock_is(1'b0);
      @(posedge ref_clk);
      rst <= 1'b0;
      rd(STATUS_OFS, 8'h00);
      rd(INT_EN_OFS, 8'h00);
      idle(2);
      stop_test();
   end
endmodule
